// ### seq_set_select_config.sv
// Parameter-set stepper in pin-chosen mode with AHB-Lite registers
`timescale 1ns/1ps
// Contract
// - A pin-chosen policy exists; software selects it before assigning sources.
// - The stored set count is programmable and limited to four.
// - With two sets only address bit 0 is used, picked automatically.
// - Either input line can drive address bit 0.
// - Above two sets, a bit pick chooses bit 0 or 1 for the source write.
// - A slot pick of 0 to 3 names the target of the next save.
// - Software adjustments act on the active set only.
// - Save copies the active values into the picked slot.
// - Save fully replaces the previous slot contents.
// - Set address is plain binary with bit 1 most significant.
// - High line sets its bit to one; inverted lines use low instead.
// - Each frame start while on, in pin-chosen policy and between frames, samples lines and loads the addressed set.
// - Turning off finishes the frame, then restores the prior active values.
module seq_set_select_config
  import seq_cfg_pkg::*;
(
  // Clock and reset
  input  logic               core_clk,
  input  logic               reset_n,
  // AHB-Lite slave
  input  logic               hsel,
  input  logic [31:0]        haddr,
  input  logic [1:0]         htrans,
  input  logic               hwrite,
  input  logic [2:0]         hsize,
  input  logic [31:0]        hwdata,
  input  logic               hready,
  output logic               hreadyout,
  output logic               hresp,
  output logic [31:0]        hrdata,
  // External lines
  input  logic               input_pin_a,
  input  logic               input_pin_b,
  // Frame timing
  input  logic               frame_start_trig,
  input  logic               frame_done,
  // Active set and status
  output logic [PARAM_W-1:0] active_value,
  output logic [SET_W-1:0]   cur_set,
  output logic               frame_busy
);

  logic               ph_valid_ff;
  logic               nxt_ph_valid;
  logic               ph_write_ff;
  logic               nxt_ph_write;
  logic [7:0]         ph_addr_ff;
  logic [7:0]         nxt_ph_addr;
  logic [31:0]        hrdata_ff;
  logic [31:0]        nxt_hrdata;
  logic [31:0]        rd_value;
  logic               on_ff;
  logic               nxt_on;
  logic               policy_ff;
  logic               nxt_policy;
  logic [1:0]         inv_ff;
  logic [1:0]         nxt_inv;
  logic [2:0]         count_ff;
  logic [2:0]         nxt_count;
  logic               pick_ff;
  logic               nxt_pick;
  logic [1:0]         src_ff;
  logic [1:0]         nxt_src;
  logic [SET_W-1:0]   slot_ff;
  logic [SET_W-1:0]   nxt_slot;
  logic [PARAM_W-1:0] active_ff;
  logic [PARAM_W-1:0] nxt_active;
  logic [PARAM_W-1:0] backup_ff;
  logic [PARAM_W-1:0] nxt_backup;
  logic [SET_W-1:0]   cur_set_ff;
  logic [SET_W-1:0]   nxt_cur_set;
  stepper_state_t     state_ff;
  stepper_state_t     nxt_state;
  logic [LINE_N-1:0]  pins_sync;
  logic [SET_W-1:0]   sel_addr;
  logic               eff_pick;
  logic               cfg_lock;
  logic               take;
  logic               wr_ctrl;
  logic               wr_src;
  logic               wr_slot;
  logic               wr_cmd;
  logic               wr_active;
  logic               save_go;
  logic               trig_go;

  set_mem_if mem_bus ();

  // Clamp a written set count into the legal range
  function automatic logic [2:0] clamp_count(input logic [2:0] v);
    logic [2:0] r;
    r = v;
    if (v > MAX_SETS) begin
      r = MAX_SETS;
    end else if (v < MIN_SETS) begin
      r = MIN_SETS;
    end
    return r;
  endfunction

  // Line synchronisers
  line_sync u_sync (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .pins_raw  ({input_pin_b, input_pin_a}),
    .pins_sync (pins_sync)
  );

  // Saved set storage
  set_store u_store (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .mem      (mem_bus.store)
  );

  // Fixed bus answers
  assign hreadyout    = 1'h1;
  assign hresp        = 1'h0;
  assign hrdata       = hrdata_ff;
  assign active_value = active_ff;
  assign cur_set      = cur_set_ff;
  assign frame_busy   = (state_ff == ST_FRAME);

  // Data-phase write strobes
  assign take      = hsel & hready & htrans[1];
  assign wr_ctrl   = ph_valid_ff & ph_write_ff & (ph_addr_ff == OFS_CTRL);
  assign wr_src    = ph_valid_ff & ph_write_ff & (ph_addr_ff == OFS_ADDR_SRC);
  assign wr_slot   = ph_valid_ff & ph_write_ff & (ph_addr_ff == OFS_SLOT);
  assign wr_cmd    = ph_valid_ff & ph_write_ff & (ph_addr_ff == OFS_CMD);
  assign wr_active = ph_valid_ff & ph_write_ff & (ph_addr_ff == OFS_ACTIVE);

  // Policy, count, sources and saves are frozen while the stepper runs
  assign cfg_lock = on_ff | (state_ff != ST_OFF);

  // Two sets imply bit 0 without a pick
  assign eff_pick = (count_ff == MIN_SETS) ? 1'h0 : pick_ff;

  // Set address from the chosen lines
  assign sel_addr[0] = pins_sync[src_ff[0]] ^ inv_ff[src_ff[0]];
  assign sel_addr[1] = (count_ff == MIN_SETS) ? 1'h0 :
                       (pins_sync[src_ff[1]] ^ inv_ff[src_ff[1]]);

  // Memory port
  assign save_go         = wr_cmd & hwdata[CMD_SAVE_BIT] & ~cfg_lock;
  assign mem_bus.wr_en   = save_go;
  assign mem_bus.wr_idx  = slot_ff;
  assign mem_bus.wr_data = active_ff;
  assign mem_bus.rd_idx  = sel_addr;

  // Read mux
  always_comb begin
    rd_value = 32'h0000_0000;
    case (haddr[7:0])
      OFS_CTRL: begin
        rd_value[CTRL_ON_BIT]                = on_ff;
        rd_value[CTRL_POLICY_BIT]            = policy_ff;
        rd_value[CTRL_INV_LSB +: LINE_N]     = inv_ff;
        rd_value[CTRL_COUNT_LSB +: 3]        = count_ff;
      end
      OFS_ADDR_SRC: begin
        rd_value[SRC_PICK_BIT]               = eff_pick;
        rd_value[SRC_LINE_BIT]               = src_ff[eff_pick];
        rd_value[SRC0_RD_BIT]                = src_ff[0];
        rd_value[SRC1_RD_BIT]                = src_ff[1];
      end
      OFS_SLOT:   rd_value[SET_W-1:0]        = slot_ff;
      OFS_ACTIVE: rd_value                   = active_ff;
      OFS_STATUS: begin
        rd_value[STAT_ADDR_LSB +: SET_W]     = cur_set_ff;
        rd_value[STAT_STATE_LSB +: 3]        = state_ff;
        rd_value[STAT_PINS_LSB +: LINE_N]    = pins_sync;
      end
      default:    rd_value                   = 32'h0000_0000;
    endcase
  end

  // Address phase capture
  always_comb begin
    nxt_ph_valid = ph_valid_ff;
    nxt_ph_write = ph_write_ff;
    nxt_ph_addr  = ph_addr_ff;
    nxt_hrdata   = hrdata_ff;
    if (hready) begin
      nxt_ph_valid = take;
      nxt_ph_write = hwrite;
      nxt_ph_addr  = haddr[7:0];
      if (take && !hwrite) begin
        nxt_hrdata = rd_value;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ph_valid_ff <= 1'h0;
      ph_write_ff <= 1'h0;
      ph_addr_ff  <= 8'h00;
      hrdata_ff   <= 32'h0000_0000;
    end else begin
      ph_valid_ff <= nxt_ph_valid;
      ph_write_ff <= nxt_ph_write;
      ph_addr_ff  <= nxt_ph_addr;
      hrdata_ff   <= nxt_hrdata;
    end
  end

  // Configuration registers
  always_comb begin
    nxt_on     = on_ff;
    nxt_policy = policy_ff;
    nxt_inv    = inv_ff;
    nxt_count  = count_ff;
    nxt_pick   = eff_pick;
    nxt_src    = src_ff;
    nxt_slot   = slot_ff;
    if (wr_ctrl) begin
      nxt_on  = hwdata[CTRL_ON_BIT];
      nxt_inv = hwdata[CTRL_INV_LSB +: LINE_N];
      if (!cfg_lock) begin
        nxt_policy = hwdata[CTRL_POLICY_BIT];
        nxt_count  = clamp_count(hwdata[CTRL_COUNT_LSB +: 3]);
      end
    end
    if (wr_src && !cfg_lock) begin
      nxt_pick = (count_ff == MIN_SETS) ? 1'h0 : hwdata[SRC_PICK_BIT];
      nxt_src[nxt_pick] = hwdata[SRC_LINE_BIT];
    end
    if (wr_slot) begin
      nxt_slot = hwdata[SET_W-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      on_ff     <= 1'h0;
      policy_ff <= RST_POLICY;
      inv_ff    <= 2'h0;
      count_ff  <= RST_COUNT;
      pick_ff   <= 1'h0;
      src_ff    <= RST_SRC;
      slot_ff   <= 2'h0;
    end else begin
      on_ff     <= nxt_on;
      policy_ff <= nxt_policy;
      inv_ff    <= nxt_inv;
      count_ff  <= nxt_count;
      pick_ff   <= nxt_pick;
      src_ff    <= nxt_src;
      slot_ff   <= nxt_slot;
    end
  end

  // Frame start taken only in pin-chosen policy
  assign trig_go = frame_start_trig & on_ff & policy_ff;

  // Stepper state and active set
  always_comb begin
    nxt_state   = state_ff;
    nxt_active  = active_ff;
    nxt_backup  = backup_ff;
    nxt_cur_set = cur_set_ff;
    if (wr_active) begin
      nxt_active = hwdata;
    end
    unique case (state_ff)
      ST_OFF: begin
        if (on_ff) begin
          nxt_backup = active_ff;
          nxt_state  = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!on_ff) begin
          nxt_active = backup_ff;
          nxt_state  = ST_OFF;
        end else if (trig_go) begin
          nxt_active  = mem_bus.rd_data;
          nxt_cur_set = sel_addr;
          nxt_state   = ST_FRAME;
        end
      end
      ST_FRAME: begin
        if (frame_done && on_ff) begin
          nxt_state = ST_WAIT;
        end else if (frame_done) begin
          nxt_active = backup_ff;
          nxt_state  = ST_OFF;
        end
      end
      default: nxt_state = ST_OFF;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff   <= ST_OFF;
      active_ff  <= RST_ACTIVE;
      backup_ff  <= RST_ACTIVE;
      cur_set_ff <= 2'h0;
    end else begin
      state_ff   <= nxt_state;
      active_ff  <= nxt_active;
      backup_ff  <= nxt_backup;
      cur_set_ff <= nxt_cur_set;
    end
  end

  chk_count_limit: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    count_ff <= MAX_SETS && count_ff >= MIN_SETS)
    else $error("set count outside two to four");

  chk_two_set_bit: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    count_ff == MIN_SETS |-> sel_addr[1] == 1'h0 && eff_pick == 1'h0)
    else $error("bit 1 or pick active with two sets");

  chk_trig_load: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    state_ff == ST_WAIT && on_ff && trig_go |=>
      active_ff == $past(mem_bus.rd_data) && cur_set_ff == $past(sel_addr)
      && state_ff == ST_FRAME)
    else $error("frame start did not load the addressed set");

  chk_off_restore: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    $past(state_ff) != ST_OFF && state_ff == ST_OFF |-> active_ff == $past(backup_ff))
    else $error("active set not restored on stop");

  chk_frame_finish: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    state_ff == ST_FRAME && !frame_done |=> state_ff == ST_FRAME)
    else $error("frame left before its end");

  chk_save_target: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    wr_cmd && hwdata[CMD_SAVE_BIT] && state_ff == ST_OFF && !on_ff |->
      mem_bus.wr_en && mem_bus.wr_idx == slot_ff && mem_bus.wr_data == active_ff)
    else $error("save missed or aimed at the wrong slot");

  chk_active_adjust: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    wr_active && state_ff == ST_OFF && !on_ff |=> active_ff == $past(hwdata))
    else $error("active set write lost");

  chk_bit_polarity: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !inv_ff[0] && src_ff[0] == 1'h0 |-> sel_addr[0] == pins_sync[0])
    else $error("bit 0 does not follow a non-inverted line");

  chk_source_write: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    wr_src && !cfg_lock && count_ff != MIN_SETS |=>
      src_ff[$past(hwdata[SRC_PICK_BIT])] == $past(hwdata[SRC_LINE_BIT]))
    else $error("source write not applied to picked bit");

endmodule

// ### seq_cfg_pkg.sv
// Shared constants and types for the parameter-set stepper configuration
package seq_cfg_pkg;

  // Widths and sizes
  localparam int PARAM_W  = 32;
  localparam int SET_W    = 2;
  localparam int NUM_SETS = 4;
  localparam int LINE_N   = 2;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_ADDR_SRC = 8'h04;
  localparam logic [7:0] OFS_SLOT     = 8'h08;
  localparam logic [7:0] OFS_CMD      = 8'h0C;
  localparam logic [7:0] OFS_ACTIVE   = 8'h10;
  localparam logic [7:0] OFS_STATUS   = 8'h14;

  // Control register fields
  localparam int CTRL_ON_BIT     = 0;
  localparam int CTRL_POLICY_BIT = 1;
  localparam int CTRL_INV_LSB    = 2;
  localparam int CTRL_COUNT_LSB  = 4;

  // Address source register fields
  localparam int SRC_PICK_BIT = 0;
  localparam int SRC_LINE_BIT = 1;
  localparam int SRC0_RD_BIT  = 4;
  localparam int SRC1_RD_BIT  = 5;

  // Command and status fields
  localparam int CMD_SAVE_BIT   = 0;
  localparam int STAT_ADDR_LSB  = 0;
  localparam int STAT_STATE_LSB = 4;
  localparam int STAT_PINS_LSB  = 8;

  // Set count limits and reset values
  localparam logic [2:0]         MAX_SETS   = 3'h4;
  localparam logic [2:0]         MIN_SETS   = 3'h2;
  localparam logic [2:0]         RST_COUNT  = 3'h4;
  localparam logic               RST_POLICY = 1'h1;
  localparam logic [1:0]         RST_SRC    = 2'h2;
  localparam logic [PARAM_W-1:0] RST_ACTIVE = 32'h0000_0000;

  // Stepper states
  typedef enum logic [2:0] {
    ST_OFF   = 3'h1,
    ST_WAIT  = 3'h2,
    ST_FRAME = 3'h4
  } stepper_state_t;

endpackage

// ### set_mem_if.sv
// Port bundle between the stepper and its stored-set memory
`timescale 1ns/1ps
interface set_mem_if;
  import seq_cfg_pkg::*;
  logic               wr_en;
  logic [SET_W-1:0]   wr_idx;
  logic [PARAM_W-1:0] wr_data;
  logic [SET_W-1:0]   rd_idx;
  logic [PARAM_W-1:0] rd_data;

  modport owner (output wr_en, wr_idx, wr_data, rd_idx, input rd_data);
  modport store (input wr_en, wr_idx, wr_data, rd_idx, output rd_data);
endinterface

// ### line_sync.sv
// Two-stage synchronisers for the external input lines
`timescale 1ns/1ps
module line_sync
  import seq_cfg_pkg::*;
(
  // Clock and reset
  input  logic              core_clk,
  input  logic              reset_n,
  // Lines
  input  logic [LINE_N-1:0] pins_raw,
  output logic [LINE_N-1:0] pins_sync
);

  genvar g;
  generate
    for (g = 0; g < LINE_N; g++) begin : g_bit
      logic meta_ff;
      logic nxt_meta;
      logic sync_ff;
      logic nxt_sync;

      // Next values of both stages
      always_comb begin
        nxt_meta = pins_raw[g];
        nxt_sync = meta_ff;
      end

      // Stage registers
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          meta_ff <= 1'h0;
          sync_ff <= 1'h0;
        end else begin
          meta_ff <= nxt_meta;
          sync_ff <= nxt_sync;
        end
      end

      assign pins_sync[g] = sync_ff;
    end
  endgenerate

  chk_sync_delay: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    $past(reset_n) && $past(reset_n, 2) |-> pins_sync == $past(pins_raw, 2))
    else $error("line synchroniser delay is not two cycles");

endmodule

// ### set_store.sv
// Storage for the saved parameter sets
`timescale 1ns/1ps
module set_store
  import seq_cfg_pkg::*;
(
  // Clock and reset
  input  logic     core_clk,
  input  logic     reset_n,
  // Memory port
  set_mem_if.store mem
);

  logic [PARAM_W-1:0] slot_rd [NUM_SETS];

  genvar g;
  generate
    for (g = 0; g < NUM_SETS; g++) begin : g_slot
      logic [PARAM_W-1:0] word_ff;
      logic [PARAM_W-1:0] nxt_word;

      // Save overwrites the whole word
      always_comb begin
        nxt_word = word_ff;
        if (mem.wr_en && (mem.wr_idx == SET_W'(g))) begin
          nxt_word = mem.wr_data;
        end
      end

      // Word register
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          word_ff <= RST_ACTIVE;
        end else begin
          word_ff <= nxt_word;
        end
      end

      assign slot_rd[g] = word_ff;

      chk_slot_write: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        mem.wr_en && (mem.wr_idx == SET_W'(g)) |=> word_ff == $past(mem.wr_data))
        else $error("saved set does not hold the stored value");
    end
  endgenerate

  // Read selected set
  assign mem.rd_data = slot_rd[mem.rd_idx];

endmodule

// ### line_frame_drv.sv
// Model of the external equipment: input lines and frame timing pulses
`timescale 1ns/1ps
module line_frame_drv (
  // Clock and reset
  input  logic       core_clk,
  input  logic       reset_n,
  // Requests from the bench
  input  logic [1:0] lines_set,
  input  logic       go,
  input  logic [7:0] hold,
  // Lines and frame pulses
  output logic       input_pin_a,
  output logic       input_pin_b,
  output logic       frame_start_trig,
  output logic       frame_done
);
  logic [7:0] cnt_ff;
  logic [1:0] st_ff;

  // Lines follow the requested levels and stay put until the next request
  assign {input_pin_b, input_pin_a} = lines_set;

  // Settle time, one trigger pulse, frame length, one done pulse
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff           <= 8'h00;
      st_ff            <= 2'h0;
      frame_start_trig <= 1'b0;
      frame_done       <= 1'b0;
    end else begin
      frame_start_trig <= 1'b0;
      frame_done       <= 1'b0;
      case (st_ff)
        2'h0: begin
          if (go) begin
            cnt_ff <= 8'h04; // Lines settle well before the trigger
            st_ff  <= 2'h1;
          end
        end
        2'h1: begin
          if (cnt_ff == 8'h00) begin
            frame_start_trig <= 1'b1;
            cnt_ff           <= hold;
            st_ff            <= 2'h2;
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        default: begin
          if (cnt_ff == 8'h00) begin
            frame_done <= 1'b1;
            st_ff      <= 2'h0;
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
      endcase
    end
  end
endmodule

// ### seq_set_select_config_test.sv
// Self-checking bench for the stepper configuration block
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module seq_set_select_config_test
  import seq_cfg_pkg::*;
;
  logic               core_clk, reset_n, hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0]         htrans, lines_set;
  logic [2:0]         hsize;
  logic [31:0]        haddr, hwdata, hrdata, rdat;
  logic [7:0]         hold;
  logic               go, pin_a, pin_b, trig, fdone, frame_busy, seen;
  logic [PARAM_W-1:0] active_value;
  logic [SET_W-1:0]   cur_set;
  logic [31:0]        sv [4];
  logic [31:0]        base_val;
  int                 failures, cmp_count;

  // Single slave: its ready is the bus ready
  assign hready = hreadyout;

  // Clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  seq_set_select_config u_dut (
    .core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .input_pin_a(pin_a), .input_pin_b(pin_b), .frame_start_trig(trig),
    .frame_done(fdone), .active_value(active_value), .cur_set(cur_set),
    .frame_busy(frame_busy)
  );

  line_frame_drv u_far (
    .core_clk(core_clk), .reset_n(reset_n), .lines_set(lines_set), .go(go),
    .hold(hold), .input_pin_a(pin_a), .input_pin_b(pin_b),
    .frame_start_trig(trig), .frame_done(fdone)
  );

  // Control word: on, pin-chosen policy, invert B:A, set count
  function automatic logic [31:0] cv(input logic on, input logic [1:0] inv,
                                     input logic [2:0] n);
    return {25'h000_0000, n, inv, 1'b1, on};
  endfunction

  // One AHB-Lite single transfer, address phase then data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= d;
    do @(posedge core_clk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, rdat);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000, rdat);
    `CHK(rdat, e)
    `CHK(hresp, 1'b0)
  endtask

  // Run one frame with given lines; long frames return once busy
  task automatic frame(input logic [1:0] l, input logic [1:0] e, input logic [7:0] h);
    lines_set <= l;
    hold      <= h;
    go        <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    do @(negedge core_clk); while (frame_busy !== 1'b1);
    `CHK(cur_set, e)
    `CHK(active_value, sv[e])
    if (h < 8'h10) begin
      do @(negedge core_clk); while (frame_busy !== 1'b0);
    end
    @(posedge core_clk);
  endtask

  task automatic say(input string n);
    $display("test %s done", n);
  endtask

  // Pulse a trigger and expect no frame to start
  task automatic no_frame();
    go   <= 1'b1;
    hold <= 8'h03;
    @(posedge core_clk);
    go   <= 1'b0;
    seen = 1'b0;
    repeat (12) begin
      @(negedge core_clk);
      seen = seen | (frame_busy === 1'b1);
    end
    `CHK(seen, 1'b0)
    @(posedge core_clk);
  endtask

  // Reset values and an unmapped offset
  task automatic t_reset();
    rdchk(OFS_CTRL, 32'h0000_0042);
    rdchk(OFS_ADDR_SRC, 32'h0000_0020);
    rdchk(OFS_STATUS, 32'h0000_0010);
    rdchk(OFS_SLOT, 32'h0000_0000);
    wr(8'h18, 32'hFFFF_FFFF);
    rdchk(8'h18, 32'h0000_0000);
    say("reset");
  endtask

  // Count limits and the automatic bit pick at two sets
  task automatic t_count();
    wr(OFS_CTRL, cv(1'b0, 2'b00, 3'h7));
    rdchk(OFS_CTRL, cv(1'b0, 2'b00, 3'h4));
    wr(OFS_CTRL, cv(1'b0, 2'b00, 3'h1));
    rdchk(OFS_CTRL, cv(1'b0, 2'b00, 3'h2));
    wr(OFS_ADDR_SRC, 32'h0000_0003);
    rdchk(OFS_ADDR_SRC, 32'h0000_0032);
    wr(OFS_CTRL, cv(1'b0, 2'b00, 3'h3));
    rdchk(OFS_CTRL, cv(1'b0, 2'b00, 3'h3));
    wr(OFS_CTRL, cv(1'b0, 2'b00, 3'h4));
    say("count");
  endtask

  // Source assignment per bit, then fill every slot twice
  task automatic t_store();
    wr(OFS_ADDR_SRC, 32'h0000_0000);
    wr(OFS_ADDR_SRC, 32'h0000_0003);
    rdchk(OFS_ADDR_SRC, 32'h0000_0023);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_SLOT, 32'(i));
      rdchk(OFS_SLOT, 32'(i));
      wr(OFS_ACTIVE, 32'hDEAD_BEEF);
      wr(OFS_CMD, 32'h0000_0001);
      wr(OFS_ACTIVE, sv[i]);
      rdchk(OFS_ACTIVE, sv[i]);
      wr(OFS_CMD, 32'h0000_0001);
    end
    wr(OFS_ACTIVE, base_val);
    say("store");
  endtask

  // Every address, inversion, then stop mid-frame and restore
  task automatic t_frames();
    wr(OFS_CTRL, cv(1'b1, 2'b00, 3'h4));
    rdchk(OFS_CTRL, cv(1'b1, 2'b00, 3'h4));
    rdchk(OFS_STATUS, 32'h0000_0020);
    wr(OFS_ADDR_SRC, 32'h0000_0000);
    rdchk(OFS_ADDR_SRC, 32'h0000_0023);
    wr(OFS_CMD, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      frame(2'(i), 2'(i), 8'h03);
    end
    wr(OFS_CTRL, cv(1'b1, 2'b01, 3'h4));
    frame(2'b00, 2'b01, 8'h03);
    frame(2'b11, 2'b10, 8'h03);
    frame(2'b10, 2'b11, 8'h28);
    wr(OFS_CTRL, cv(1'b0, 2'b00, 3'h4));
    `CHK(frame_busy, 1'b1)
    `CHK(active_value, sv[3])
    do @(negedge core_clk); while (frame_busy !== 1'b0);
    `CHK(active_value, base_val)
    @(posedge core_clk);
    no_frame();
    say("frames");
  endtask

  // Lines swapped between bits, then two sets with bit 1 ignored
  task automatic t_swap();
    wr(OFS_ADDR_SRC, 32'h0000_0002);
    wr(OFS_ADDR_SRC, 32'h0000_0001);
    rdchk(OFS_ADDR_SRC, 32'h0000_0011);
    wr(OFS_CTRL, cv(1'b1, 2'b00, 3'h4));
    frame(2'b01, 2'b10, 8'h03);
    wr(OFS_CTRL, cv(1'b0, 2'b00, 3'h4));
    wr(OFS_CTRL, cv(1'b0, 2'b00, 3'h2));
    wr(OFS_ADDR_SRC, 32'h0000_0003);
    wr(OFS_CTRL, cv(1'b1, 2'b00, 3'h2));
    frame(2'b11, 2'b01, 8'h03);
    frame(2'b01, 2'b00, 8'h03);
    wr(OFS_CTRL, 32'h0000_0020);
    wr(OFS_CTRL, 32'h0000_0021);
    rdchk(OFS_CTRL, 32'h0000_0021);
    no_frame();
    say("swap");
  endtask

  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    failures  = 0;
    cmp_count = 0;
    reset_n   = 1'b0;
    hsel      = 1'b0;
    haddr     = 32'h0000_0000;
    htrans    = 2'b00;
    hwrite    = 1'b0;
    hsize     = 3'h2;
    hwdata    = 32'h0000_0000;
    go        = 1'b0;
    hold      = 8'h00;
    lines_set = 2'b00;
    base_val  = 32'h1234_5678;
    sv        = '{32'h1111_1111, 32'h2222_2222, 32'h3333_3333, 32'h4444_4444};
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_count();
    t_store();
    t_frames();
    t_swap();
    end_sim();
  end

  // Hang guard, far above the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    end_sim();
  end
endmodule
